// [rtl/omx_pkg.sv]
// Shared constants and types for the output mixer, router and level block
package omx_pkg;

    // ======================================================================
    // Sizes
    localparam int SW       = 24;   // Sample width
    localparam int CW       = 16;   // Coefficient width, unity 0x8000
    localparam int N_IN     = 16;   // 8 analogue, 2 digital, 6 optical
    localparam int N_PAIR   = 4;    // Output pairs
    localparam int N_SRC    = N_IN + 2;
    localparam int PW       = 2;    // Pair index width

    // ======================================================================
    // Reset values and figures
    localparam logic [CW-1:0] UNITY_RST   = 16'h8000;
    localparam logic [CW-1:0] PAN_CTR_RST = 16'h8000;
    localparam int            SMOOTH_SH   = 4;   // Smoothing step 1/16
    // Overload threshold: -0.05dBFS of 2^23 full scale, ~0.99426
    localparam logic [SW-2:0] OVL_LVL     = 23'h7F43EA;
    localparam logic [SW-2:0] GREEN_LVL   = 23'h080000;
    localparam logic [SW-2:0] ORANGE_LVL  = 23'h200000;
    localparam int            HOLD_MS     = 3000;
    localparam int            CLK_KHZ     = 250000;
    localparam int            FLASH_BITS  = 25;  // Ring flash period
    localparam logic [SW-1:0] FS_POS      = 24'h7FFFFF;
    localparam logic [SW-1:0] FS_NEG      = 24'h800000;

    // ======================================================================
    // Types
    typedef struct packed {
        logic signed [SW-1:0] l;
        logic signed [SW-1:0] r;
    } omx_stereo_t;

    typedef struct packed {
        logic [CW-1:0] gain;
        logic [CW-1:0] pan;    // 0 full left, 0xFFFF full right
        logic          mute;
        logic          solo;
    } omx_chan_ctl_t;

    typedef enum logic [2:0] {
        OMX_IDLE = 3'b001,
        OMX_HELD = 3'b010,
        OMX_DONE = 3'b100
    } omx_knob_t;

    typedef enum logic [2:0] {
        OMX_BLUE   = 3'b001,
        OMX_GREEN  = 3'b010,
        OMX_ORANGE = 3'b100
    } omx_color_t;

endpackage

// [rtl/omx_mixer.sv]
// Output mixers, routing matrix, assignable level, headphone tap and meters
`timescale 1ns/1ps
module omx_mixer
    import omx_pkg::*;
#(
    parameter int HOLD_CYC = HOLD_MS * CLK_KHZ,
    // Short widths let a bench see the ring flash in a few cycles
    parameter int FLASH_W  = FLASH_BITS
) (
    input  wire logic                     clk_i,
    input  wire logic                     rst_n_i,
    input  wire logic                     sample_en_i,
    input  wire logic [N_IN*SW-1:0]       in_smp_i,
    input  wire omx_pkg::omx_stereo_t     host_feed_i [N_PAIR],
    input  wire logic [N_PAIR-1:0]        host_feed_mode_i,
    input  wire omx_pkg::omx_chan_ctl_t   in_ctl_i [N_PAIR][N_IN],
    input  wire logic [N_IN/2-1:0]        stereo_link_i,
    input  wire omx_pkg::omx_chan_ctl_t   bus_ctl_i [N_PAIR],
    input  wire logic [PW-1:0]            route_sel_i [N_PAIR],
    input  wire logic [PW-1:0]            hp_sel_i,
    input  wire logic [N_PAIR-1:0]        level_assign_i,
    input  wire logic [CW-1:0]            level_i,
    input  wire logic                     knob_press_i,
    input  wire logic                     module_fitted_i,
    input  wire logic                     host_direct_monitoring_i,
    input  wire logic                     dm_mute_i,
    input  wire logic                     meter_out_sel_i,
    input  wire logic [7:0]               limiting_i,
    output omx_pkg::omx_stereo_t          out_o [N_PAIR],
    output omx_pkg::omx_stereo_t          hp_o,
    output logic [N_PAIR-1:0]             bus_ovl_o,
    output logic [3:0]                    panel_ovl_o,
    output omx_pkg::omx_color_t           panel_color_o [4],
    output logic [7:0]                    limit_led_o,
    output logic                          ring_flash_o,
    output logic                          mute_state_o,
    output logic                          module_host_o,
    output logic                          host_led_red_o,
    output logic                          host_led_green_o
);
    import omx_pkg::*;

    // ======================================================================
    // Helpers
    function automatic logic signed [SW-1:0] sat(input logic signed [47:0] v);
        if (v > 48'sh7FFFFF) return FS_POS;
        else if (v < -48'sh800000) return FS_NEG;
        else return v[SW-1:0];
    endfunction

    function automatic logic signed [47:0] mulc(input logic signed [SW-1:0] s,
                                                input logic [CW-1:0] c);
        logic signed [47:0] p;
        p = 48'(s) * $signed({1'b0, c});
        return p >>> 15;
    endfunction

    function automatic logic [CW-1:0] smooth(input logic [CW-1:0] cur,
                                             input logic [CW-1:0] tgt);
        logic signed [CW+1:0] d;
        d = $signed({2'b00, tgt}) - $signed({2'b00, cur});
        return cur + CW'(d >>> SMOOTH_SH) + CW'(d != 0 && (d >>> SMOOTH_SH) == 0
               ? (d > 0 ? 1 : -1) : 0);
    endfunction

    function automatic logic [SW-2:0] mag(input logic signed [SW-1:0] s);
        return s[SW-1] ? (s == FS_NEG ? FS_POS[SW-2:0] : (SW-1)'(-s))
                       : s[SW-2:0];
    endfunction

    function automatic omx_color_t color(input logic [SW-2:0] m);
        if (m >= ORANGE_LVL) return OMX_ORANGE;
        else if (m >= GREEN_LVL) return OMX_GREEN;
        else return OMX_BLUE;
    endfunction

    // ======================================================================
    // Coefficient smoothing state, one step per sample
    logic [CW-1:0] gl_reg [N_PAIR][N_IN], gl_next [N_PAIR][N_IN];
    logic [CW-1:0] gr_reg [N_PAIR][N_IN], gr_next [N_PAIR][N_IN];
    logic [CW-1:0] bg_reg [N_PAIR], bg_next [N_PAIR];
    logic [CW-1:0] lv_reg, lv_next;

    always_comb begin
        logic [CW-1:0] g, p, tl, tr;
        logic          m, any_solo, sl;
        int            k;
        g = '0; p = '0; tl = '0; tr = '0; m = 1'b0; any_solo = 1'b0;
        sl = 1'b0; k = 0;
        lv_next = sample_en_i ? smooth(lv_reg, level_i) : lv_reg;
        for (int o = 0; o < N_PAIR; o++) begin
            any_solo = 1'b0;
            for (int i = 0; i < N_IN; i++) begin
                k = stereo_link_i[i/2] ? (i & ~1) : i;
                any_solo = any_solo | in_ctl_i[o][k].solo;
            end
            for (int i = 0; i < N_IN; i++) begin
                sl = stereo_link_i[i/2];
                k = sl ? (i & ~1) : i;
                g = in_ctl_i[o][k].gain;
                p = in_ctl_i[o][k].pan;
                m = in_ctl_i[o][k].mute | (any_solo & ~in_ctl_i[o][k].solo);
                if (host_direct_monitoring_i && !host_feed_mode_i[o])
                    m = m | dm_mute_i;
                // Linear pan law; linked pair uses balance on each side
                tl = sl ? (i[0] ? '0 : (p[CW-1] ? CW'(~p) << 1 : '1))
                        : ~p;
                tr = sl ? (i[0] ? (p[CW-1] ? '1 : p << 1) : '0) : p;
                if (m) begin
                    tl = '0;
                    tr = '0;
                end
                tl = CW'((32'(g) * 32'(tl)) >> 16);
                tr = CW'((32'(g) * 32'(tr)) >> 16);
                gl_next[o][i] = sample_en_i ? smooth(gl_reg[o][i], tl)
                                            : gl_reg[o][i];
                gr_next[o][i] = sample_en_i ? smooth(gr_reg[o][i], tr)
                                            : gr_reg[o][i];
            end
            g = bus_ctl_i[o].mute ? '0 : bus_ctl_i[o].gain;
            bg_next[o] = sample_en_i ? smooth(bg_reg[o], g) : bg_reg[o];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int o = 0; o < N_PAIR; o++) begin
                bg_reg[o] <= UNITY_RST;
                for (int i = 0; i < N_IN; i++) begin
                    gl_reg[o][i] <= '0;
                    gr_reg[o][i] <= '0;
                end
            end
            lv_reg <= UNITY_RST;
        end else begin
            gl_reg <= gl_next;
            gr_reg <= gr_next;
            bg_reg <= bg_next;
            lv_reg <= lv_next;
        end
    end

    // ======================================================================
    // Mix, route, level; whole datapath one stage per sample
    omx_stereo_t mix     [N_PAIR];
    omx_stereo_t out_next [N_PAIR], out_reg [N_PAIR];
    omx_stereo_t hp_next, hp_reg;
    logic        mute_reg, mute_next;

    always_comb begin
        logic signed [47:0] al, ar;
        logic signed [SW-1:0] s;
        omx_stereo_t src;
        al = '0; ar = '0; s = '0; src = '0;
        for (int o = 0; o < N_PAIR; o++) begin
            al = mulc(host_feed_i[o].l, bg_reg[o] == '0 ? '0 : UNITY_RST);
            ar = mulc(host_feed_i[o].r, bg_reg[o] == '0 ? '0 : UNITY_RST);
            for (int i = 0; i < N_IN; i++) begin
                s = in_smp_i[i*SW +: SW];
                al = al + mulc(s, gl_reg[o][i]);
                ar = ar + mulc(s, gr_reg[o][i]);
            end
            mix[o].l = sat(mulc(sat(al), bg_reg[o]));
            mix[o].r = sat(mulc(sat(ar), bg_reg[o]));
            if (host_feed_mode_i[o])
                mix[o] = host_feed_i[o];
        end
        // Routing first, level after, so ganged outputs differ in level
        for (int o = 0; o < N_PAIR; o++) begin
            src = mix[route_sel_i[o]];
            if (level_assign_i[o]) begin
                src.l = mute_reg ? '0 : sat(mulc(src.l, lv_reg));
                src.r = mute_reg ? '0 : sat(mulc(src.r, lv_reg));
            end
            out_next[o] = sample_en_i ? src : out_reg[o];
        end
        // Headphones tap the mixer ahead of routing and level
        hp_next = sample_en_i ? mix[hp_sel_i] : hp_reg;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int o = 0; o < N_PAIR; o++)
                out_reg[o] <= '0;
            hp_reg <= '0;
        end else begin
            out_reg <= out_next;
            hp_reg  <= hp_next;
        end
    end

    // ======================================================================
    // Knob press: short press toggles mute, 3 s hold selects module host if one is fitted
    logic [2:0]  kb_sync_reg;
    logic        kb_lvl_reg, kb_lvl_next;
    omx_knob_t   kst_reg, kst_next;
    logic [31:0] hold_reg, hold_next;
    logic        mod_reg, mod_next;
    logic [FLASH_W-1:0] fl_reg, fl_next;

    always_comb begin
        kb_lvl_next = (kb_sync_reg[2] == kb_sync_reg[1]) ? kb_sync_reg[2]
                                                         : kb_lvl_reg;
        kst_next  = kst_reg;
        hold_next = hold_reg;
        mute_next = mute_reg;
        mod_next  = mod_reg;
        fl_next   = fl_reg + 1'b1;
        unique case (kst_reg)
            OMX_IDLE: begin
                hold_next = '0;
                if (kb_lvl_reg) kst_next = OMX_HELD;
            end
            OMX_HELD: begin
                hold_next = hold_reg + 1'b1;
                if (!kb_lvl_reg) begin
                    mute_next = ~mute_reg;
                    kst_next  = OMX_IDLE;
                end else if (hold_reg >= 32'(HOLD_CYC - 1)) begin
                    if (module_fitted_i) mod_next = 1'b1;
                    kst_next = OMX_DONE;
                end
            end
            OMX_DONE: begin
                if (!kb_lvl_reg) kst_next = OMX_IDLE;
            end
        endcase
        if (!module_fitted_i) mod_next = 1'b0;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            kb_sync_reg <= '0;
            kb_lvl_reg  <= 1'b0;
            kst_reg     <= OMX_IDLE;
            hold_reg    <= '0;
            mute_reg    <= 1'b0;
            mod_reg     <= 1'b0;
            fl_reg      <= '0;
        end else begin
            kb_sync_reg <= {kb_sync_reg[1:0], knob_press_i};
            kb_lvl_reg  <= kb_lvl_next;
            kst_reg     <= kst_next;
            hold_reg    <= hold_next;
            mute_reg    <= mute_next;
            mod_reg     <= mod_next;
            fl_reg      <= fl_next;
        end
    end

    // ======================================================================
    // Meters: peak per sample, overload at -0.05dBFS
    logic [N_PAIR-1:0] bovl_next, bovl_reg;
    logic [3:0]        povl_next, povl_reg;
    omx_color_t        pcol_next [4], pcol_reg [4];
    logic [7:0]        lim_next, lim_reg;
    logic              flash_next, flash_reg;

    always_comb begin
        logic signed [SW-1:0] ch [4];
        ch = '{default: '0};
        for (int o = 0; o < N_PAIR; o++)
            bovl_next[o] = mag(mix[o].l) >= OVL_LVL || mag(mix[o].r) >= OVL_LVL;
        // Left pair analogue 1/2 or output 0, right pair digital input or output 1
        ch[0] = meter_out_sel_i ? out_reg[0].l : in_smp_i[0*SW +: SW];
        ch[1] = meter_out_sel_i ? out_reg[0].r : in_smp_i[1*SW +: SW];
        ch[2] = meter_out_sel_i ? out_reg[1].l : in_smp_i[8*SW +: SW];
        ch[3] = meter_out_sel_i ? out_reg[1].r : in_smp_i[9*SW +: SW];
        for (int m = 0; m < 4; m++) begin
            povl_next[m] = mag(ch[m]) >= OVL_LVL;
            pcol_next[m] = color(mag(ch[m]));
        end
        // Limiter lamps only mean anything while metering inputs
        lim_next   = meter_out_sel_i ? '0 : limiting_i;
        flash_next = mute_reg & fl_reg[FLASH_W-1];
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bovl_reg  <= '0;
            povl_reg  <= '0;
            for (int m = 0; m < 4; m++)
                pcol_reg[m] <= OMX_BLUE;
            lim_reg   <= '0;
            flash_reg <= 1'b0;
        end else begin
            bovl_reg  <= bovl_next;
            povl_reg  <= povl_next;
            pcol_reg  <= pcol_next;
            lim_reg   <= lim_next;
            flash_reg <= flash_next;
        end
    end

    // ======================================================================
    // Outputs, all from flops
    assign out_o            = out_reg;
    assign hp_o             = hp_reg;
    assign bus_ovl_o        = bovl_reg;
    assign panel_ovl_o      = povl_reg;
    assign panel_color_o    = pcol_reg;
    assign limit_led_o      = lim_reg;
    assign ring_flash_o     = flash_reg;
    assign mute_state_o     = mute_reg;
    assign module_host_o    = mod_reg;
    assign host_led_red_o   = mod_reg;
    assign host_led_green_o = ~mod_reg;
endmodule

// [dv/omx_mixer_sva.sv]
// Port-level assertions for the output mixer block
`timescale 1ns/1ps
module omx_mixer_sva
    import omx_pkg::*;
(
    input wire logic                 clk_i,
    input wire logic                 rst_n_i,
    input wire logic                 sample_en_i,
    input wire omx_pkg::omx_stereo_t host_feed_i [N_PAIR],
    input wire logic [N_PAIR-1:0]    host_feed_mode_i,
    input wire logic [PW-1:0]        hp_sel_i,
    input wire logic                 module_fitted_i,
    input wire logic                 meter_out_sel_i,
    input wire omx_pkg::omx_stereo_t out_o [N_PAIR],
    input wire omx_pkg::omx_stereo_t hp_o,
    input wire omx_pkg::omx_color_t  panel_color_o [4],
    input wire logic [7:0]           limit_led_o,
    input wire logic                 ring_flash_o,
    input wire logic                 mute_state_o,
    input wire logic                 module_host_o,
    input wire logic                 host_led_red_o,
    input wire logic                 host_led_green_o
);
    import omx_pkg::*;
    // ==========
    // Checks, all in the one clock domain
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Strobe while the headphone source pair runs in host-feed mode
    sequence hp_host_smp;
        sample_en_i && host_feed_mode_i[hp_sel_i];
    endsequence
    // Two cycles of output metering, so the lamp register has caught up
    sequence meter_out_2;
        meter_out_sel_i [*2];
    endsequence
    led_pair_a:
        assert property (host_led_green_o != host_led_red_o)
        else $error("host lamp colours disagree");
    led_host_a:
        assert property (host_led_red_o == module_host_o)
        else $error("host lamp does not follow host select");
    fit_host_a:
        assert property ($rose(module_host_o) |-> $past(module_fitted_i))
        else $error("module host chosen without a module");
    flash_mute_a:
        assert property (ring_flash_o |-> mute_state_o || $past(mute_state_o))
        else $error("ring flashes while not muted");
    lamp_off_a:
        assert property (meter_out_2 |=> limit_led_o == 8'h00)
        else $error("limiter lamps lit in output metering");
    hp_tap_a:
        assert property (hp_host_smp |=> hp_o == $past(host_feed_i[hp_sel_i]))
        else $error("headphones differ from host feed");
    out_hold_a:
        assert property (!sample_en_i |=> $stable(out_o[0]) && $stable(hp_o))
        else $error("audio outputs moved between samples");
    color_hot_a:
        assert property ($onehot(panel_color_o[0]))
        else $error("meter colour not one-hot");
endmodule

// [dv/omx_host_model.sv]
// Host side model: per-pair stereo feeds from one base value
`timescale 1ns/1ps
module omx_host_model
    import omx_pkg::*;
(
    input  wire logic [SW-1:0]   base_i,
    output omx_pkg::omx_stereo_t feed_o [N_PAIR]
);
    import omx_pkg::*;
    // ==========
    // Feeds
    // Distinct per pair so a misroute shows; whole stereo units only
    always_comb begin
        for (int k = 0; k < N_PAIR; k++) begin
            feed_o[k].l = base_i + SW'(k * 'h1000);
            feed_o[k].r = base_i - SW'(k * 'h100);
        end
    end
endmodule

// [dv/tb.sv]
// Self-checking bench for the output mixer, router and level block
`timescale 1ns/1ps
module tb;
    import omx_pkg::*;
    // ==========
    // Signals
    localparam int HOLD = 20;
    logic               clk_i, rst_n_i, knob, fit, msel, flash, mst;
    logic               mhost, red, green, dm, dmm;
    logic               smp = 1'b0;
    logic [1:0]         scnt = 2'h0;
    logic [N_IN*SW-1:0] ins;
    logic [N_PAIR-1:0]  mode, asg, bovl;
    logic [CW-1:0]      lvl;
    logic [7:0]         lim, lled, link;
    logic [3:0]         povl;
    logic [SW-1:0]      base;
    logic [PW-1:0]      rsel [N_PAIR];
    logic [PW-1:0]      hsel;
    omx_chan_ctl_t      ictl [N_PAIR][N_IN];
    omx_chan_ctl_t      bctl [N_PAIR];
    omx_stereo_t        feed [N_PAIR];
    omx_stereo_t        outs [N_PAIR];
    omx_stereo_t        hp;
    omx_color_t         pcol [4];
    int                 failures, checked, hits;
    // ==========
    // Block and host model; short knob hold and ring flash for simulation
    omx_mixer #(.HOLD_CYC(HOLD), .FLASH_W(4)) u_omx_mixer (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .sample_en_i(smp),
        .in_smp_i(ins), .host_feed_i(feed), .host_feed_mode_i(mode),
        .in_ctl_i(ictl), .stereo_link_i(link), .bus_ctl_i(bctl),
        .route_sel_i(rsel), .hp_sel_i(hsel), .level_assign_i(asg),
        .level_i(lvl), .knob_press_i(knob), .module_fitted_i(fit),
        .host_direct_monitoring_i(dm), .dm_mute_i(dmm),
        .meter_out_sel_i(msel), .limiting_i(lim), .out_o(outs), .hp_o(hp),
        .bus_ovl_o(bovl), .panel_ovl_o(povl), .panel_color_o(pcol),
        .limit_led_o(lled), .ring_flash_o(flash), .mute_state_o(mst),
        .module_host_o(mhost), .host_led_red_o(red),
        .host_led_green_o(green)
    );
    omx_host_model u_omx_host_model (.base_i(base), .feed_o(feed));
    // ==========
    // Clock, reset, and a sample strobe every fourth cycle
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    initial begin
        rst_n_i = 1'b0;
        repeat (10) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
    end
    always @(posedge clk_i) begin
        #1 scnt = scnt + 2'h1;
        smp = rst_n_i && scnt == 2'h0;
    end
    // ==========
    // Helpers
    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // One extra edge so the registered answer has landed
    task automatic wait_smp(input int n);
        repeat (n) @(posedge smp);
        @(posedge clk_i);
        #1;
    endtask
    // Margin covers the synchroniser and the toggle delay
    task automatic press(input int c);
        knob = 1'b1;
        repeat (c) @(posedge clk_i);
        #1 knob = 1'b0;
        repeat (12) @(posedge clk_i);
        #1;
    endtask
    // A 4-bit flash counter gives 8 lit cycles in every 16
    task automatic count_flash();
        hits = 0;
        repeat (16) begin
            @(posedge clk_i);
            #1 hits += int'(flash);
        end
    endtask
    task automatic stop_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Watchdog: the tests need about 13k cycles
    initial begin
        #300us;
        failures++;
        stop_test();
    end
    // ==========
    // Tests
    initial begin
        {knob, fit, msel, ins, asg, hsel, lim, link, dm, dmm} = '0;
        mode = '1;
        lvl = 16'h8000;
        base = 24'h123450;
        for (int k = 0; k < N_PAIR; k++) begin
            rsel[k] = PW'(k);
            bctl[k] = '{16'h8000, 16'h8000, 1'b0, 1'b0};
            for (int j = 0; j < N_IN; j++) begin
                ictl[k][j] = '{16'h8000, 16'h0000, 1'b0, 1'b0};
            end
        end
        wait (rst_n_i === 1'b1);
        wait_smp(8);
        check(48'({green, mhost}), 48'h2);
        for (int k = 0; k < N_PAIR; k++) begin
            check(outs[k], feed[k]);
        end
        $display("test host_feed done");
        // Outputs 2 and 3 follow mixers 0 and 1; only output 2 faded
        rsel[2] = 2'h0;
        rsel[3] = 2'h1;
        asg = 4'h4;
        lvl = 16'h0000;
        wait_smp(400);
        check(outs[2], '0);
        check(outs[0], feed[0]);
        check(outs[3], feed[1]);
        for (int k = 0; k < N_PAIR; k++) begin
            hsel = PW'(k);
            wait_smp(2);
            check(hp, feed[k]);
        end
        $display("test routing done");
        // Short press mutes assigned output 0 only; again restores
        lvl = 16'h8000;
        asg = 4'h1;
        press(4);
        check(48'(mst), 48'h1);
        wait_smp(400);
        check(outs[0], '0);
        check(outs[1], feed[1]);
        count_flash();
        check(48'(hits), 48'h8);
        press(4);
        check(48'(mst), 48'h0);
        count_flash();
        check(48'(hits), 48'h0);
        // Long press without a module neither hands over nor mutes
        press(HOLD + 10);
        check(48'({mhost, mst}), 48'h0);
        // Long press with a module fitted hands the host link over
        fit = 1'b1;
        press(HOLD + 10);
        check(48'({mhost, red, green, mst}), 48'hC);
        fit = 1'b0;
        wait_smp(2);
        check(48'(mhost), 48'h0);
        $display("test knob done");
        // Pair 0 mixes sixteen large inputs with its feed and clips
        mode = 4'hE;
        msel = 1'b1;
        ins = {N_IN{24'h400000}};
        base = 24'h400000;
        wait_smp(400);
        check({24'h000000, outs[0].l}, {24'h000000, FS_POS});
        check(48'({bovl[0], povl[0]}), 48'h3);
        check(48'(pcol[0]), 48'(OMX_ORANGE));
        ins = {N_IN{24'hC00000}};
        base = 24'hC00000;
        wait_smp(4);
        check({24'h000000, outs[0].l}, {24'h000000, FS_NEG});
        for (int j = 0; j < N_IN; j++) begin
            ictl[0][j].mute = 1'b1;
        end
        wait_smp(400);
        check(outs[0], feed[0]);
        bctl[0].mute = 1'b1;
        wait_smp(400);
        check(outs[0], '0);
        // Limiter lamps and input meters show only while metering inputs
        msel = 1'b0;
        lim = 8'hA5;
        wait_smp(1);
        check(48'(lled), 48'hA5);
        check(48'(pcol[0]), 48'(OMX_ORANGE));
        msel = 1'b1;
        wait_smp(1);
        check(48'(lled), 48'h00);
        check(48'(pcol[0]), 48'(OMX_BLUE));
        $display("test mix_meters done");
        // Linked inputs 0/1 obey channel 0 controls, balance centred
        ins = '0;
        ins[0 +: SW] = 24'h010000;
        ins[SW +: SW] = 24'h010000;
        base = 24'h000000;
        link = 8'h01;
        bctl[0].mute = 1'b0;
        for (int j = 0; j < N_IN; j++) begin
            ictl[0][j].mute = 1'b0;
        end
        ictl[0][0].pan = 16'h8000;
        ictl[0][1].mute = 1'b1;
        wait_smp(400);
        check(outs[0], {24'h00FFFE, 24'h00FFFE});
        // Host mute request counts only once direct monitoring is on
        dmm = 1'b1;
        wait_smp(400);
        check(outs[0], {24'h00FFFE, 24'h00FFFE});
        dm = 1'b1;
        wait_smp(400);
        check(outs[0], '0);
        $display("test link_monitor done");
        stop_test();
    end
endmodule
bind omx_mixer omx_mixer_sva u_omx_mixer_sva (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .sample_en_i(sample_en_i),
    .host_feed_i(host_feed_i), .host_feed_mode_i(host_feed_mode_i),
    .hp_sel_i(hp_sel_i), .module_fitted_i(module_fitted_i),
    .meter_out_sel_i(meter_out_sel_i), .out_o(out_o), .hp_o(hp_o),
    .panel_color_o(panel_color_o), .limit_led_o(limit_led_o),
    .ring_flash_o(ring_flash_o), .mute_state_o(mute_state_o),
    .module_host_o(module_host_o), .host_led_red_o(host_led_red_o),
    .host_led_green_o(host_led_green_o)
);
